// >>> sac_defines.vh
/*
 * Constants for the converter control block: state codes, timing
 * figures and the cycle counts derived from them.
 * Assumes a 250 MHz core clock; included by its bare name.
 */
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// Core clock period
`define SAC_CLK_NS        4

// Acquisition phase, least time
`define SAC_ACQ_NS        400
// Time given to each bit decision, least time
`define SAC_BIT_NS        64
// Half period of the internally made shift clock, least time
`define SAC_SCLK_HALF_NS  24

// Cycle counts, least times rounded up
`define SAC_ACQ_CYC       ((`SAC_ACQ_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_BIT_CYC       ((`SAC_BIT_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_SCLK_HALF_CYC ((`SAC_SCLK_HALF_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)

// Result width and bits in one serial frame
`define SAC_RES_W         16
`define SAC_FRAME_BITS    5'h10

// One-hot conversion states
`define SAC_ST_ACQ        4'h1
`define SAC_ST_ARM        4'h2
`define SAC_ST_CONV       4'h4
`define SAC_ST_PDN        4'h8

// Pin positions shared by the parallel and serial port
`define SAC_PIN_SEROUT    8
`define SAC_PIN_SCLK      9
`define SAC_PIN_FRAME     10
`define SAC_PIN_RDERR     11

`endif

// >>> sac_sync.v
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes each bit is an independent level from outside the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// >>> sac_ctrl.v
/*
 * Digital control and output port of a 16-bit successive-approximation
 * converter: acquisition, start, bit decisions, busy, power control,
 * parallel port and serial port with frame marker and read-error flag.
 * Assumes all pin inputs and the comparator are asynchronous to clk;
 * the pad ring resolves pin levels from pin_out and pin_oe_n.
 */
// Notes on behaviour
// - Pin ten: data bit or frame marker
// - Frame marker active while serial data valid
// - Pin eleven: read-error flag in slave serial
// - Unfinished slave read at completion: discard, pulse
// - Bits twelve to fifteen always outputs
// - Busy high from start until result latched
// - Output bus enabled only with select, read low
// - Chip select gates the external shift clock
// - Reset input aborts conversion and resets
// - Power-down finishes conversion, then blocks new ones
// - Start high after acquisition: wait falling edge
// - Start low after acquisition: convert at once
// - Reference on while its power-off low
// - Buffer on while its power-off low
// - Serial result shifted out MSB first
// - Shift clock made here when source select low
`timescale 1ns/1ps
`default_nettype none

`include "sac_defines.vh"

module sac_ctrl (
    input  wire        clk,
    input  wire        rst,
    input  wire        convert_start_n,
    input  wire        cs_n,
    input  wire        rd_n,
    input  wire        serial_parallel_select,
    input  wire        clock_source_select,
    input  wire        frame_marker_invert,
    input  wire        power_down_in,
    input  wire        reference_power_off,
    input  wire        buffer_power_off,
    input  wire        shift_clock_in,
    input  wire        comparator_in,
    output reg  [15:0] pin_out,
    output reg  [15:0] pin_oe_n,
    output reg         busy,
    output reg         sample_hold_hold,
    output reg  [15:0] dac_trial,
    output reg         low_power,
    output reg         reference_enable,
    output reg         buffer_enable
);

    // Counts are worked out as integers, then cut to the timer width
    localparam integer ACQ_I    = `SAC_ACQ_CYC;
    localparam integer BIT_I    = `SAC_BIT_CYC;
    localparam integer HALF_I   = `SAC_SCLK_HALF_CYC;
    localparam [7:0]   ACQ_CYC  = ACQ_I[7:0];
    localparam [7:0]   BIT_CYC  = BIT_I[7:0];
    localparam [7:0]   HALF_CYC = HALF_I[7:0];

    // Synchronised pin levels; active-low pins enter inverted so that
    // the cleared flops read as idle and no bus cycle follows reset
    wire [11:0] pins_s;
    wire        cnv_s  = ~pins_s[0];
    wire        cs_s   = ~pins_s[1];
    wire        rd_s   = ~pins_s[2];
    wire        ser_s  = pins_s[3];
    wire        ext_s  = pins_s[4];
    wire        inv_s  = pins_s[5];
    wire        pwr_s  = pins_s[6];
    wire        refo_s = pins_s[7];
    wire        bufo_s = pins_s[8];
    wire        sclk_s = pins_s[9];
    wire        cmp_s  = pins_s[10];

    sac_sync #(
        .W (12)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({1'b0, comparator_in, shift_clock_in, buffer_power_off,
                    reference_power_off, power_down_in, frame_marker_invert,
                    clock_source_select, serial_parallel_select, ~rd_n, ~cs_n,
                    ~convert_start_n}),
        .sync_out (pins_s)
    );

    // Conversion sequencer state
    reg [3:0]  state_reg;
    reg [7:0]  timer_reg;
    reg [3:0]  bit_idx_reg;
    reg [15:0] result_reg;
    reg        cnv_prev_reg;

    // Serial port state
    reg [15:0] shift_reg;
    reg        rd_active_reg;
    reg [4:0]  rd_cnt_reg;
    reg        unread_reg;
    reg        sclk_int_reg;
    reg [7:0]  sdiv_reg;
    reg        sclk_prev_reg;
    reg        rderr_reg;

    // Pin drive next values
    reg [15:0] pin_out_next;
    reg [15:0] pin_oe_n_next;

    wire bus_en    = ~cs_s & ~rd_s;
    wire slave_ser = ser_s & ext_s;
    wire cnv_fall  = cnv_prev_reg & ~cnv_s;
    wire conv_done = (state_reg == `SAC_ST_CONV) && (timer_reg == 8'h00)
                     && (bit_idx_reg == 4'h0);

    // External clock edge counts only while selected
    wire ext_edge  = slave_ser & ~cs_s & sclk_s & ~sclk_prev_reg;

    // Internal shift clock falling edge at divider terminal
    wire int_fall  = rd_active_reg & ~ext_s & sclk_int_reg & (sdiv_reg == 8'h00);

    // Bit under trial, set during its decision window
    function [15:0] bit_mask;
        input [3:0] idx;
        begin
            bit_mask = 16'h0001 << idx;
        end
    endfunction

    // Conversion sequencer: acquire, arm, convert, power down
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg        <= `SAC_ST_ACQ;
            timer_reg        <= 8'h00;
            bit_idx_reg      <= 4'h0;
            result_reg       <= 16'h0000;
            cnv_prev_reg     <= 1'b1;
            busy             <= 1'b0;
            sample_hold_hold <= 1'b0;
            dac_trial        <= 16'h0000;
            low_power        <= 1'b0;
        end else begin
            cnv_prev_reg <= cnv_s;
            case (state_reg)
                `SAC_ST_ACQ: begin
                    sample_hold_hold <= 1'b0;
                    if (pwr_s) begin
                        state_reg <= `SAC_ST_PDN;
                        low_power <= 1'b1;
                    end else if (timer_reg != ACQ_CYC) begin
                        timer_reg <= timer_reg + 8'h01;
                    end else if (cnv_s) begin
                        state_reg <= `SAC_ST_ARM;
                    end else begin
                        // Start low at end of acquisition
                        state_reg        <= `SAC_ST_CONV;
                        sample_hold_hold <= 1'b1;
                        busy             <= 1'b1;
                        bit_idx_reg      <= 4'hf;
                        timer_reg        <= BIT_CYC;
                        dac_trial        <= bit_mask(4'hf);
                    end
                end
                `SAC_ST_ARM: begin
                    if (pwr_s) begin
                        state_reg <= `SAC_ST_PDN;
                        low_power <= 1'b1;
                    end else if (cnv_fall) begin
                        // Hold taken on the start edge itself
                        state_reg        <= `SAC_ST_CONV;
                        sample_hold_hold <= 1'b1;
                        busy             <= 1'b1;
                        bit_idx_reg      <= 4'hf;
                        timer_reg        <= BIT_CYC;
                        dac_trial        <= bit_mask(4'hf);
                    end
                end
                `SAC_ST_CONV: begin
                    // Power-down is not looked at: the conversion runs out
                    if (timer_reg != 8'h00) begin
                        timer_reg <= timer_reg - 8'h01;
                    end else begin
                        // Keep the trial bit when input is at or above it
                        if (bit_idx_reg == 4'h0) begin
                            result_reg <= cmp_s ? dac_trial
                                                : (dac_trial & ~bit_mask(4'h0));
                            busy             <= 1'b0;
                            sample_hold_hold <= 1'b0;
                            timer_reg        <= 8'h00;
                            state_reg        <= `SAC_ST_ACQ;
                        end else begin
                            dac_trial <= (cmp_s ? dac_trial
                                                : (dac_trial & ~bit_mask(bit_idx_reg)))
                                         | bit_mask(bit_idx_reg - 4'h1);
                            bit_idx_reg <= bit_idx_reg - 4'h1;
                            timer_reg   <= BIT_CYC;
                        end
                    end
                end
                `SAC_ST_PDN: begin
                    // New conversions refused until power-down drops
                    if (!pwr_s) begin
                        state_reg <= `SAC_ST_ACQ;
                        low_power <= 1'b0;
                        timer_reg <= 8'h00;
                    end
                end
                default: begin
                    state_reg <= `SAC_ST_ACQ;
                    timer_reg <= 8'h00;
                end
            endcase
        end
    end

    // Shift register and read sequencing for both clock sources
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg     <= 16'h0000;
            rd_active_reg <= 1'b0;
            rd_cnt_reg    <= 5'h00;
            unread_reg    <= 1'b0;
            sclk_int_reg  <= 1'b0;
            sdiv_reg      <= 8'h00;
            sclk_prev_reg <= 1'b0;
            rderr_reg     <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            rderr_reg     <= 1'b0;
            if (conv_done) begin
                // New word replaces any half-read one
                shift_reg <= cmp_s ? dac_trial
                                   : (dac_trial & ~bit_mask(4'h0));
                unread_reg    <= 1'b1;
                rd_active_reg <= 1'b0;
                rd_cnt_reg    <= 5'h00;
                sclk_int_reg  <= 1'b0;
                sdiv_reg      <= 8'h00;
                if (rd_active_reg && slave_ser) begin
                    rderr_reg <= 1'b1;
                end
            end else if (slave_ser) begin
                // Slave: host edges move the word, MSB already shown
                if (ext_edge) begin
                    shift_reg     <= {shift_reg[14:0], 1'b0};
                    rd_cnt_reg    <= rd_cnt_reg + 5'h01;
                    rd_active_reg <= (rd_cnt_reg + 5'h01) != `SAC_FRAME_BITS;
                    unread_reg    <= 1'b0;
                end
            end else if (ser_s) begin
                // Master: divider makes the shift clock
                if (!rd_active_reg) begin
                    if (unread_reg && bus_en && !busy) begin
                        rd_active_reg <= 1'b1;
                        rd_cnt_reg    <= 5'h00;
                        sdiv_reg      <= HALF_CYC;
                        sclk_int_reg  <= 1'b0;
                    end
                end else if (sdiv_reg != 8'h00) begin
                    sdiv_reg <= sdiv_reg - 8'h01;
                end else begin
                    sdiv_reg     <= HALF_CYC;
                    sclk_int_reg <= ~sclk_int_reg;
                    if (int_fall) begin
                        shift_reg  <= {shift_reg[14:0], 1'b0};
                        rd_cnt_reg <= rd_cnt_reg + 5'h01;
                        if ((rd_cnt_reg + 5'h01) == `SAC_FRAME_BITS) begin
                            rd_active_reg <= 1'b0;
                            unread_reg    <= 1'b0;
                        end
                    end
                end
            end else if (bus_en) begin
                // Parallel read takes the whole word at once
                unread_reg <= 1'b0;
            end
        end
    end

    // Pin mapping and bus enable, registered below
    always @* begin
        pin_out_next  = 16'h0000;
        pin_oe_n_next = 16'hffff;
        if (!ser_s) begin
            pin_out_next = result_reg;
            if (bus_en) begin
                pin_oe_n_next = 16'h0000;
            end
        end else begin
            pin_out_next[15:12] = result_reg[15:12];
            pin_out_next[`SAC_PIN_SEROUT] = shift_reg[15];
            pin_out_next[`SAC_PIN_SCLK]  = sclk_int_reg;
            pin_out_next[`SAC_PIN_FRAME] = rd_active_reg ^ inv_s;
            pin_out_next[`SAC_PIN_RDERR] = rderr_reg & ext_s;
            if (bus_en) begin
                pin_oe_n_next[15:12]          = 4'h0;
                pin_oe_n_next[`SAC_PIN_SEROUT] = 1'b0;
                pin_oe_n_next[`SAC_PIN_SCLK]  = ext_s;
                pin_oe_n_next[`SAC_PIN_FRAME] = ext_s;
                pin_oe_n_next[`SAC_PIN_RDERR] = ~ext_s;
            end
        end
        // Upper nibble is an output in both modes
        if (bus_en) begin
            pin_oe_n_next[15:12] = 4'h0;
        end
    end

    // Output flops and power controls
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out          <= 16'h0000;
            pin_oe_n         <= 16'hffff;
            reference_enable <= 1'b0;
            buffer_enable    <= 1'b0;
        end else begin
            pin_out          <= pin_out_next;
            pin_oe_n         <= pin_oe_n_next;
            reference_enable <= ~refo_s;
            buffer_enable    <= ~bufo_s;
        end
    end

endmodule

`default_nettype wire

// >>> sac_ctrl_assertions.sv
/*
 * Port checker for the converter control block.
 * Assumes it is bound to sac_ctrl and that pin inputs reach the pins 3 clk later.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        serial_parallel_select,
    input wire logic        clock_source_select,
    input wire logic        frame_marker_invert,
    input wire logic        reference_power_off,
    input wire logic        buffer_power_off,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic        busy,
    input wire logic        sample_hold_hold,
    input wire logic [15:0] dac_trial,
    input wire logic        low_power,
    input wire logic        reference_enable,
    input wire logic        buffer_enable
);
    logic [2:0] up_cnt;
    wire        up = (up_cnt == 3'h7);

    // Settle count, so that $past never looks back into reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            up_cnt <= 3'h0;
        end else if (!up) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_busy_hold: assert property (busy |-> sample_hold_hold)
        else $error("busy high while sample hold open");
    a_conv_start: assert property ($rose(busy) |-> dac_trial == 16'h8000 && !$past(low_power))
        else $error("conversion began badly");
    a_conv_len: assert property ($rose(busy) |-> ##271 busy ##1 !busy)
        else $error("busy length wrong");
    a_pd_block: assert property (low_power |-> !busy)
        else $error("conversion in power down");
    a_reset_abort: assert property (disable iff (1'b0) rst && $past(rst)
        |-> !busy && pin_oe_n == 16'hffff)
        else $error("reset did not abort");
    a_bus_gate: assert property (up && !pin_oe_n[8] |-> !$past(cs_n, 3) && !$past(rd_n, 3))
        else $error("bus driven without select and read");
    a_bus_drop: assert property (up && $past(cs_n, 3) |-> pin_oe_n == 16'hffff)
        else $error("bus driven while deselected");
    a_upper_out: assert property (!pin_oe_n[8] |-> pin_oe_n[15:12] == 4'h0)
        else $error("upper bits not driven");
    a_par_word: assert property (up && !$past(serial_parallel_select, 3) && !pin_oe_n[8]
        |-> pin_oe_n == 16'h0000)
        else $error("parallel word not whole");
    a_frame_pol: assert property (up && $past(serial_parallel_select, 3) && !$past(clock_source_select, 3)
        && !pin_oe_n[9] && $rose(pin_out[9]) |-> pin_out[10] == !$past(frame_marker_invert, 3))
        else $error("frame marker level wrong");
    a_rderr_once: assert property (up && $past(serial_parallel_select, 3) && $past(clock_source_select, 3)
        && $rose(pin_out[11]) |=> !pin_out[11])
        else $error("read error flag too long");
    a_ref_follow: assert property (up |-> reference_enable == !$past(reference_power_off, 3))
        else $error("reference enable wrong");
    a_buf_follow: assert property (up |-> buffer_enable == !$past(buffer_power_off, 3))
        else $error("buffer enable wrong");
endmodule
`default_nettype wire

// >>> sac_host_model.sv
/*
 * Host on the serial port: makes the slave shift clock and collects words.
 * Assumes registered pin values from the converter; master_mode set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe_n,
    input  wire logic        master_mode,
    input  wire logic        frame_marker_invert,
    output var  logic        shift_clock_in,
    output var  logic [15:0] word,
    output wire logic        word_valid
);
    logic       s_valid, m_valid, sck_prev;
    logic [4:0] bit_cnt;
    wire        framed = master_mode && !pin_oe_n[10] && (pin_out[10] == !frame_marker_invert);

    assign word_valid = s_valid | m_valid;

    initial begin
        shift_clock_in = 1'b0;
        s_valid = 1'b0;
        m_valid = 1'b0;
        sck_prev = 1'b0;
        bit_cnt = 5'h00;
        word = 16'h0000;
    end

    // Host clock at 48 ns, still between frames; short reads flag nothing here
    task automatic read_slave(input int n);
        repeat (4) @(posedge clk);
        #1;
        for (int i = 0; i < n; i++) begin
            word = {word[14:0], pin_out[8]};
            #24 shift_clock_in = 1'b1;
            #24 shift_clock_in = 1'b0;
        end
        if (n == 16) begin
            @(negedge clk) s_valid = 1'b1;
            @(negedge clk) s_valid = 1'b0;
        end
    endtask

    // Device clock: a bit is valid at each rise while the marker is active
    always @(posedge clk) begin
        sck_prev <= pin_out[9];
        m_valid  <= 1'b0;
        if (!framed) begin
            bit_cnt <= 5'h00;
        end else if (pin_out[9] && !sck_prev) begin
            word    <= {word[14:0], pin_out[8]};
            bit_cnt <= bit_cnt + 5'h01;
            m_valid <= (bit_cnt == 5'h0f);
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 * Self-checking bench for the converter control block with a host model.
 * Assumes the design header, checker and host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rst, convert_start_n, cs_n, rd_n, ser, css, inv, pdn;
    logic        ref_off, buf_off, cmp_in, sclk, host_valid;
    logic [15:0] pin_out, pin_oe_n, dac_trial, ain, host_word, prev_oe, v;
    logic        busy, hold, low_power, ref_en, buf_en;
    logic [15:0] exp_q[$];
    logic [31:0] seed;
    int          failures, cmp_count, cyc, rderr_cnt, n;

    sac_ctrl i_dut (.clk(clk), .rst(rst), .convert_start_n(convert_start_n), .cs_n(cs_n),
        .rd_n(rd_n), .serial_parallel_select(ser), .clock_source_select(css),
        .frame_marker_invert(inv), .power_down_in(pdn), .reference_power_off(ref_off),
        .buffer_power_off(buf_off), .shift_clock_in(sclk), .comparator_in(cmp_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .busy(busy), .sample_hold_hold(hold),
        .dac_trial(dac_trial), .low_power(low_power), .reference_enable(ref_en),
        .buffer_enable(buf_en));
    sac_host_model i_host (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .master_mode(ser && !css), .frame_marker_invert(inv), .shift_clock_in(sclk),
        .word(host_word), .word_valid(host_valid));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic summarize();
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic report(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait on busy; a miss shows as a mismatch
    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        report("busy", 16'(lvl), 16'(busy));
    endtask

    // Start stays high past acquisition, so the falling edge launches it
    task automatic conv(input logic [15:0] val);
        ain <= val;
        repeat (130) @(posedge clk);
        report("idle busy", 16'h0, 16'(busy));
        convert_start_n <= 1'b0;
        wait_busy(1'b1, 10);
        convert_start_n <= 1'b1;
        ref_off <= seed[4];
        buf_off <= seed[5];
        wait_busy(1'b0, 300);
    endtask

    task automatic bus(input logic lvl);
        cs_n <= lvl;
        rd_n <= lvl;
    endtask

    task automatic pread(input logic [15:0] val);
        exp_q.push_back(val);
        bus(1'b0);
        repeat (6) @(posedge clk);
        bus(1'b1);
        repeat (6) @(posedge clk);
    endtask

    // Modes change only while the bus is released
    task automatic mode(input logic s, input logic c, input logic i);
        ser <= s;
        css <= c;
        inv <= i;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Comparator stand-in, result watcher and hang limit
    always @(posedge clk) begin
        cmp_in <= (ain >= dac_trial);
        prev_oe <= pin_oe_n;
        cyc <= cyc + 1;
        if (pin_oe_n === 16'h0000 && prev_oe !== 16'h0000)
            report("parallel", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, pin_out);
        if (host_valid === 1'b1)
            report("serial", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, host_word);
        if (pin_out[11] === 1'b1 && pin_oe_n[11] === 1'b0 && ser && css)
            rderr_cnt <= rderr_cnt + 1;
        if (cyc == 30000) begin
            failures++;
            $display("ERROR timeout expected done seen running");
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        convert_start_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        ser = 1'b0;
        css = 1'b0;
        inv = 1'b0;
        pdn = 1'b0;
        ref_off = 1'b0;
        buf_off = 1'b1;
        ain = 16'h0000;
        cmp_in = 1'b0;
        prev_oe = 16'hffff;
        seed = 32'h18;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Parallel words: both extreme codes, then a random one
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            v = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : seed[15:0];
            conv(v);
            pread(v);
        end
        // Slave read left unfinished, then a deselected clock burst
        mode(1'b1, 1'b1, 1'b0);
        seed = xs(seed);
        conv(seed[15:0]);
        bus(1'b0);
        i_host.read_slave(5);
        seed = xs(seed);
        v = seed[15:0];
        conv(v);
        // Flag pulse reaches the pin and the counter a few edges after busy falls
        repeat (3) @(posedge clk);
        report("read error pulses", 16'h1, 16'(rderr_cnt));
        cs_n <= 1'b1;
        i_host.read_slave(3);
        cs_n <= 1'b0;
        exp_q.push_back(v);
        i_host.read_slave(16);
        bus(1'b1);
        // Device-clocked frames with both marker polarities
        for (int k = 0; k < 2; k++) begin
            mode(1'b1, 1'b0, k[0]);
            seed = xs(seed);
            conv(seed[15:0]);
            exp_q.push_back(seed[15:0]);
            bus(1'b0);
            n = 0;
            while (host_valid !== 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            report("frame end", 16'h1, 16'(host_valid));
            bus(1'b1);
            repeat (6) @(posedge clk);
        end
        // Start already low when acquisition ends, power-down asked mid-conversion
        mode(1'b0, 1'b0, 1'b0);
        // Start goes low right after a conversion, inside the next acquisition
        conv(v);
        seed = xs(seed);
        v = seed[15:0];
        ain <= v;
        convert_start_n <= 1'b0;
        wait_busy(1'b1, 200);
        report("acquisition wait", 16'h1, 16'(n >= 98 && n <= 110));
        pdn <= 1'b1;
        convert_start_n <= 1'b1;
        wait_busy(1'b0, 300);
        pread(v);
        repeat (130) @(posedge clk);
        report("low power", 16'h1, 16'(low_power));
        convert_start_n <= 1'b0;
        repeat (50) @(posedge clk);
        report("power-down busy", 16'h0, 16'(busy));
        convert_start_n <= 1'b1;
        pdn <= 1'b0;
        // Reset in mid-conversion
        repeat (130) @(posedge clk);
        convert_start_n <= 1'b0;
        wait_busy(1'b1, 10);
        repeat (40) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        report("busy after reset", 16'h0, 16'(busy));
        rst <= 1'b0;
        convert_start_n <= 1'b1;
        repeat (10) @(posedge clk);
        summarize();
    end
endmodule

bind sac_ctrl sac_ctrl_assertions i_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .serial_parallel_select(serial_parallel_select), .clock_source_select(clock_source_select),
    .frame_marker_invert(frame_marker_invert), .reference_power_off(reference_power_off),
    .buffer_power_off(buffer_power_off), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .busy(busy),
    .sample_hold_hold(sample_hold_hold), .dac_trial(dac_trial), .low_power(low_power),
    .reference_enable(reference_enable), .buffer_enable(buffer_enable));
`default_nettype wire
